/* File: shared/iotsm_regs.vh */
`ifndef IOTSM_REGS_VH
`define IOTSM_REGS_VH
// ==========================================================================
// Status word bit positions
`define IOTSM_IN_FWD_BIT     4'd0
`define IOTSM_IN_REV_BIT     4'd1
`define IOTSM_IN_GEN1_BIT    4'd2
`define IOTSM_IN_GEN2_BIT    4'd3
`define IOTSM_IN_GEN3_BIT    4'd4
`define IOTSM_IN_LFWD_BIT    4'd13
`define IOTSM_IN_LREV_BIT    4'd14
`define IOTSM_IN_LRST_BIT    4'd15
`define IOTSM_OUT_TR_BIT     4'd0
`define IOTSM_OUT_RELAY_BIT  4'd8
// ==========================================================================
// Segment bit positions within a digit byte {dp,g,f,e,d,c,b,a}
`define IOTSM_SEG_A          3'd0
`define IOTSM_SEG_B          3'd1
`define IOTSM_SEG_C          3'd2
`define IOTSM_SEG_D          3'd3
`define IOTSM_SEG_E          3'd4
`define IOTSM_SEG_F          3'd5
`define IOTSM_SEG_G          3'd6
`define IOTSM_SEG_DP         3'd7
// ==========================================================================
// Reset values and special patterns
`define IOTSM_DIGIT_RESET    8'h00
`define IOTSM_DASH_PATTERN   8'h40
// ==========================================================================
// Display view select codes
`define IOTSM_VIEW_SEGMENT   2'd0
`define IOTSM_VIEW_HEX_IN    2'd1
`define IOTSM_VIEW_HEX_OUT   2'd2
`endif

/* File: logic/iotsm_monitor.v */
// Behaviour
// - Digit one segments a-e show five inputs
// - Digit three segment a shows transistor output
// - Digit four segment a shows relay contact
// - All inputs and outputs off gives four dashes in segment view
// - Hex word sixteen bits, unused bits zero
// - Nibbles shown, high on digit four
// - Forward bit0, reverse bit1, general bits2-4
// - Input bit one when shorted to common
// - Transistor output at output bit zero
// - Relay normally open state at bit eight
// - Link mode adds three command inputs
// - Link commands shown non-inverted
// - Jumper picks sink or source common
`timescale 1ns/1ps
`default_nettype none
`include "iotsm_regs.vh"

module iotsm_monitor (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_n,
  // Input terminal contacts: high while shorted to sink common
  input  wire       forward_run_sink,
  input  wire       reverse_run_sink,
  input  wire       general_one_sink,
  input  wire       general_two_sink,
  input  wire       general_three_sink,
  // Input terminal contacts: high while shorted to source common
  input  wire       forward_run_source,
  input  wire       reverse_run_source,
  input  wire       general_one_source,
  input  wire       general_two_source,
  input  wire       general_three_source,
  // Wiring jumper: high selects source wiring
  input  wire       jumper_source_sel,
  // Output terminals
  input  wire       transistor_output_closed,
  input  wire       relay_normally_open_made,
  // Serial link commands and link mode
  input  wire       link_forward_command,
  input  wire       link_reverse_command,
  input  wire       link_reset_command,
  input  wire       link_mode,
  // Register port
  input  wire [1:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [15:0] reg_rdata,
  // Display digits {dp,g,f,e,d,c,b,a}, active high
  output reg  [7:0] digit_one,
  output reg  [7:0] digit_two,
  output reg  [7:0] digit_three,
  output reg  [7:0] digit_four
);

  // ========================================================================
  // Register map
  localparam [1:0] ADDR_CTRL     = 2'd0;
  localparam [1:0] ADDR_IN_WORD  = 2'd1;
  localparam [1:0] ADDR_OUT_WORD = 2'd2;

  // ========================================================================
  // Hex digit to segment pattern
  function [7:0] hex_to_seg;
    input [3:0] nib;
    begin
      case (nib)
        4'h0: hex_to_seg = 8'h3f;
        4'h1: hex_to_seg = 8'h06;
        4'h2: hex_to_seg = 8'h5b;
        4'h3: hex_to_seg = 8'h4f;
        4'h4: hex_to_seg = 8'h66;
        4'h5: hex_to_seg = 8'h6d;
        4'h6: hex_to_seg = 8'h7d;
        4'h7: hex_to_seg = 8'h07;
        4'h8: hex_to_seg = 8'h7f;
        4'h9: hex_to_seg = 8'h6f;
        4'ha: hex_to_seg = 8'h77;
        4'hb: hex_to_seg = 8'h7c;
        4'hc: hex_to_seg = 8'h39;
        4'hd: hex_to_seg = 8'h5e;
        4'he: hex_to_seg = 8'h79;
        default: hex_to_seg = 8'h71;
      endcase
    end
  endfunction

  // ========================================================================
  // View select register
  reg  [1:0]  view_sel;
  reg  [15:0] in_word;
  reg  [15:0] out_word;
  reg  [15:0] next_in_word;
  reg  [15:0] next_out_word;
  reg  [7:0]  next_one;
  reg  [7:0]  next_two;
  reg  [7:0]  next_three;
  reg  [7:0]  next_four;
  reg  [4:0]  inputs_on;
  reg  [2:0]  link_cmds;

  // Software view selection and read back
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      view_sel  <= `IOTSM_VIEW_SEGMENT;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == ADDR_CTRL) begin
        view_sel <= reg_wdata[1:0];
      end
      if (reg_rd) begin
        case (reg_addr)
          ADDR_CTRL:     reg_rdata <= {14'h0000, view_sel};
          ADDR_IN_WORD:  reg_rdata <= in_word;
          ADDR_OUT_WORD: reg_rdata <= out_word;
          default:       reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // ========================================================================
  // Terminal sampling and status words
  always @* begin
    // Common reference chosen by jumper
    if (jumper_source_sel) begin
      inputs_on = {general_three_source, general_two_source, general_one_source,
                   reverse_run_source, forward_run_source};
    end else begin
      inputs_on = {general_three_sink, general_two_sink, general_one_sink,
                   reverse_run_sink, forward_run_sink};
    end
    // Commands taken as received, only in link mode
    link_cmds = link_mode ? {link_reset_command, link_reverse_command,
                             link_forward_command} : 3'b000;
    next_in_word = 16'h0000;
    next_in_word[`IOTSM_IN_FWD_BIT]  = inputs_on[0];
    next_in_word[`IOTSM_IN_REV_BIT]  = inputs_on[1];
    next_in_word[`IOTSM_IN_GEN1_BIT] = inputs_on[2];
    next_in_word[`IOTSM_IN_GEN2_BIT] = inputs_on[3];
    next_in_word[`IOTSM_IN_GEN3_BIT] = inputs_on[4];
    next_in_word[`IOTSM_IN_LFWD_BIT] = link_cmds[0];
    next_in_word[`IOTSM_IN_LREV_BIT] = link_cmds[1];
    next_in_word[`IOTSM_IN_LRST_BIT] = link_cmds[2];
    next_out_word = 16'h0000;
    next_out_word[`IOTSM_OUT_TR_BIT]    = transistor_output_closed;
    next_out_word[`IOTSM_OUT_RELAY_BIT] = relay_normally_open_made;
  end

  // ========================================================================
  // Digit patterns for the selected view
  always @* begin
    next_one   = `IOTSM_DIGIT_RESET;
    next_two   = `IOTSM_DIGIT_RESET;
    next_three = `IOTSM_DIGIT_RESET;
    next_four  = `IOTSM_DIGIT_RESET;
    case (view_sel)
      `IOTSM_VIEW_HEX_IN: begin
        next_one   = hex_to_seg(next_in_word[3:0]);
        next_two   = hex_to_seg(next_in_word[7:4]);
        next_three = hex_to_seg(next_in_word[11:8]);
        next_four  = hex_to_seg(next_in_word[15:12]);
      end
      `IOTSM_VIEW_HEX_OUT: begin
        next_one   = hex_to_seg(next_out_word[3:0]);
        next_two   = hex_to_seg(next_out_word[7:4]);
        next_three = hex_to_seg(next_out_word[11:8]);
        next_four  = hex_to_seg(next_out_word[15:12]);
      end
      default: begin
        if (inputs_on == 5'b00000 && link_cmds == 3'b000 &&
            !transistor_output_closed && !relay_normally_open_made) begin
          next_one   = `IOTSM_DASH_PATTERN;
          next_two   = `IOTSM_DASH_PATTERN;
          next_three = `IOTSM_DASH_PATTERN;
          next_four  = `IOTSM_DASH_PATTERN;
        end else begin
          next_one[`IOTSM_SEG_A]   = inputs_on[0];
          next_one[`IOTSM_SEG_B]   = inputs_on[1];
          next_one[`IOTSM_SEG_C]   = inputs_on[2];
          next_one[`IOTSM_SEG_D]   = inputs_on[3];
          next_one[`IOTSM_SEG_E]   = inputs_on[4];
          next_two[`IOTSM_SEG_F]   = link_cmds[0];
          next_two[`IOTSM_SEG_G]   = link_cmds[1];
          next_two[`IOTSM_SEG_DP]  = link_cmds[2];
          next_three[`IOTSM_SEG_A] = transistor_output_closed;
          next_four[`IOTSM_SEG_A]  = relay_normally_open_made;
        end
      end
    endcase
  end

  // ========================================================================
  // Display and status registers, refreshed every clock
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_word     <= 16'h0000;
      out_word    <= 16'h0000;
      digit_one   <= `IOTSM_DIGIT_RESET;
      digit_two   <= `IOTSM_DIGIT_RESET;
      digit_three <= `IOTSM_DIGIT_RESET;
      digit_four  <= `IOTSM_DIGIT_RESET;
    end else begin
      in_word     <= next_in_word;
      out_word    <= next_out_word;
      digit_one   <= next_one;
      digit_two   <= next_two;
      digit_three <= next_three;
      digit_four  <= next_four;
    end
  end

endmodule // iotsm_monitor
`default_nettype wire

/* File: testbench/iotsm_monitor_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks for the terminal monitor
module iotsm_checker (
  // Clock, reset and terminals
  input wire logic        core_clk, rst_n, forward_run_sink, reverse_run_sink, general_one_sink,
  input wire logic        general_two_sink, general_three_sink, forward_run_source, reverse_run_source,
  input wire logic        general_one_source, general_two_source, general_three_source, jumper_source_sel,
  input wire logic        transistor_output_closed, relay_normally_open_made, link_forward_command,
  input wire logic        link_reverse_command, link_reset_command, link_mode, reg_wr, reg_rd,
  // Register port and display
  input wire logic [1:0]  reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata,
  input wire logic [7:0]  digit_one, digit_two, digit_three, digit_four
);
  localparam logic [7:0] HX [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
                                     8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  logic [1:0] view;
  wire  [4:0] ins = jumper_source_sel ? {general_three_source, general_two_source, general_one_source,
    reverse_run_source, forward_run_source} : {general_three_sink, general_two_sink, general_one_sink,
    reverse_run_sink, forward_run_sink};
  wire  [2:0] lk  = link_mode ? {link_reset_command, link_reverse_command, link_forward_command} : 3'h0;
  wire        seg = view[0] == view[1];
  wire        any = |{ins, lk, transistor_output_closed, relay_normally_open_made};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Mirror of the view control
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n) view <= 2'h0;
    else if (reg_wr && reg_addr == 2'h0) view <= reg_wdata[1:0];
  property p_in_seg; $past(rst_n) && $past(seg && any) |-> digit_one == {3'h0, $past(ins)}; endproperty
  a_in_seg: assert property (p_in_seg) else $error("digit one wrong");
  property p_tr_seg; $past(rst_n) && $past(seg && any) |-> digit_three == {7'h0, $past(transistor_output_closed)};
  endproperty
  a_tr_seg: assert property (p_tr_seg) else $error("digit three wrong");
  property p_rl_seg; $past(rst_n) && $past(seg && any) |-> digit_four == {7'h0, $past(relay_normally_open_made)};
  endproperty
  a_rl_seg: assert property (p_rl_seg) else $error("digit four wrong");
  property p_dash; $past(rst_n) && $past(seg && !any) |-> {digit_four, digit_three, digit_two, digit_one} == 32'h40404040;
  endproperty
  a_dash: assert property (p_dash) else $error("dashes missing");
  property p_lk_seg; $past(rst_n) && $past(seg && any) |-> digit_two == {$past(lk), 5'h0}; endproperty
  a_lk_seg: assert property (p_lk_seg) else $error("digit two wrong");
  property p_hex_in; $past(rst_n) && $past(view) == 2'h1 |-> digit_one == HX[$past(ins[3:0])] &&
    digit_four == HX[{$past(lk), 1'b0}] && digit_three == 8'h3f; endproperty
  a_hex_in: assert property (p_hex_in) else $error("input hex wrong");
  property p_hex_out; $past(rst_n) && $past(view) == 2'h2 |-> digit_one == HX[{3'h0, $past(transistor_output_closed)}]
    && digit_three == HX[{3'h0, $past(relay_normally_open_made)}] && digit_four == 8'h3f; endproperty
  a_hex_out: assert property (p_hex_out) else $error("output hex wrong");
  property p_rd_idle; $past(rst_n) && !$past(reg_rd) |-> reg_rdata == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule  // iotsm_checker
bind iotsm_monitor iotsm_checker chk_u (.*);
`default_nettype wire

/* File: testbench/iotsm_terminals.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Terminal wiring model
module iotsm_terminals (
  // Contacts and jumper
  input  wire logic       jumper_source_sel,
  input  wire logic [4:0] contacts,
  // Lines per common
  output      logic [4:0] sink_lines,
  output      logic [4:0] source_lines
);
  // Unselected common shows the inverse
  assign sink_lines   = jumper_source_sel ? ~contacts : contacts;
  assign source_lines = jumper_source_sel ? contacts : ~contacts;
endmodule  // iotsm_terminals
`default_nettype wire

/* File: testbench/iotsm_monitor_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Monitor testbench
module iotsm_monitor_tb_top;
  logic        core_clk, rst_n, jumper, tr, relay, lmode, wr, rd;
  logic [4:0]  contacts, sink, source;
  logic [2:0]  lk;
  logic [1:0]  addr, mview;
  logic [15:0] wdata, rdata, exp_rd;
  logic [7:0]  d1, d2, d3, d4;
  logic [31:0] exp_d;
  int          n_fail, check_count;
  localparam logic [7:0] HX [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
                                     8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  `define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
  iotsm_terminals term_u (.jumper_source_sel(jumper), .contacts(contacts), .sink_lines(sink), .source_lines(source));
  iotsm_monitor dut_u (.core_clk(core_clk), .rst_n(rst_n), .forward_run_sink(sink[0]), .reverse_run_sink(sink[1]),
    .general_one_sink(sink[2]), .general_two_sink(sink[3]), .general_three_sink(sink[4]),
    .forward_run_source(source[0]), .reverse_run_source(source[1]), .general_one_source(source[2]),
    .general_two_source(source[3]), .general_three_source(source[4]), .jumper_source_sel(jumper),
    .transistor_output_closed(tr), .relay_normally_open_made(relay), .link_forward_command(lk[0]),
    .link_reverse_command(lk[1]), .link_reset_command(lk[2]), .link_mode(lmode), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .digit_one(d1), .digit_two(d2),
    .digit_three(d3), .digit_four(d4));
  // Expected digits {four,three,two,one}
  function automatic logic [31:0] model(logic [1:0] v);
    logic [2:0]  l;
    logic [15:0] w;
    l = lmode ? lk : 3'h0;
    w = v == 2'd1 ? {l, 8'h0, contacts} : {7'h0, relay, 7'h0, tr};
    if (v == 2'd1 || v == 2'd2) return {HX[w[15:12]], HX[w[11:8]], HX[w[7:4]], HX[w[3:0]]};
    if ({contacts, l, tr, relay} == 10'h0) return 32'h40404040;
    return {7'h0, relay, 7'h0, tr, l, 5'h0, 3'h0, contacts};
  endfunction
  // Verdict
  task automatic end_sim();
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Watchdog
  initial begin
    repeat (4000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end
  // Random traffic with reads, writes and all-off phases
  initial begin
    {rst_n, jumper, tr, relay, lmode, wr, rd, contacts, lk, addr, wdata} = '0;
    mview = 2'h0;
    exp_d = 32'h40404040;
    exp_rd = 16'h0;
    void'($urandom(32'h82ec));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 3000; k++) begin
      @(posedge core_clk);
      rd <= k % 4 == 1;
      wr <= k % 4 == 3;
      addr <= 2'($urandom);
      wdata <= 16'($urandom);
      if (k % 4 != 1) {jumper, tr, relay, lmode, contacts, lk} <= k % 8 == 0 ? 12'h0 : 12'($urandom);
      @(negedge core_clk);
      `CHK("digits", exp_d, {d4, d3, d2, d1})
      `CHK("rdata", exp_rd, rdata)
      exp_d = model(mview);
      exp_rd = !rd ? 16'h0 : addr == 2'd0 ? {14'h0, mview} : addr == 2'd1 ? {lmode ? lk : 3'h0, 8'h0, contacts} :
               addr == 2'd2 ? {7'h0, relay, 7'h0, tr} : 16'h0;
      if (wr && addr == 2'd0) mview = wdata[1:0];
    end
    end_sim();
  end
endmodule  // iotsm_monitor_tb_top
`default_nettype wire
